// ===== common/gtimer_pkg.sv
package gtimer_pkg;
    // ==========================================================
    // register map, word-aligned byte addresses
    localparam logic [11:0] ADDR_COUNT_LOW = 12'h000;
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'h004;
    localparam logic [11:0] ADDR_TIMER_CTRL = 12'h008;
    localparam logic [11:0] ADDR_GATE_CTRL = 12'h00c;
    localparam logic [11:0] ADDR_GATE_SRC = 12'h010;
    localparam logic [11:0] ADDR_FLAGS = 12'h014;
    localparam logic [11:0] ADDR_ENABLES = 12'h018;
    // ==========================================================
    // timer_control_reg fields
    localparam int TC_ON = 0;
    localparam int TC_WIDE = 1;
    localparam int TC_UNSYNC = 2;
    localparam int TC_PRE_LO = 4;
    // gate_control_reg fields
    localparam int GC_LEVEL = 2;
    localparam int GC_ARMED = 3;
    localparam int GC_ONESHOT = 4;
    localparam int GC_TOGGLE = 5;
    localparam int GC_POL = 6;
    localparam int GC_EN = 7;
    // flag / enable register fields
    localparam int FL_OVF = 0;
    localparam int FL_GATE = 1;
    localparam int EN_GLOBAL = 2;
    // ==========================================================
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int GATE_SOURCES = 32;

    typedef struct packed {
        logic on;
        logic wide;
        logic unsync;
        logic [1:0] prescale;
    } timer_ctrl_t;

    typedef struct packed {
        logic enable;
        logic polarity;
        logic toggle;
        logic oneshot;
    } gate_ctrl_t;
endpackage : gtimer_pkg

// ===== dv/count_gate_src.sv
`timescale 1ns/1ns
// ==========================================================
// far side: external count clock and gate candidates
module count_gate_src (
    output logic count_clk, // link clock, low between bursts
    output logic [31:0] gate_input // gate candidates
);
    // idle clock stands low so no stray rising edge is counted
    initial begin
        count_clk = 1'b0;
        gate_input = 32'h0000_0000;
    end
    // burst of rising edges, 320 ns period, phase unrelated to pclk
    task automatic pulses(input int n);
        #7;
        repeat (n) begin
            count_clk = 1'b1;
            #160;
            count_clk = 1'b0;
            #160;
        end
    endtask : pulses
    // other candidates get the opposite level so a wrong select shows
    task automatic set_gate(input int idx, input logic v);
        gate_input = {32{~v}};
        gate_input[idx] = v;
    endtask : set_gate
endmodule : count_gate_src

// ===== dv/gated_sixteen_bit_timer_tb_top.sv
`timescale 1ns/1ns
module gated_sixteen_bit_timer_tb_top;
    // ==========================================================
    // stimulus and model state
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic sleep = 1'b0;
    logic [31:0] prdata, gate_input, rd;
    logic pready, pslverr, count_clk, overflow_irq, gate_irq, wake, err;
    logic [7:0] lo;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 4098;
    int m_cnt = 0;
    int m_pre = 0;
    int m_div = 1;
    int gsel;

    always #20 pclk = ~pclk;

    gated_sixteen_bit_timer gated_sixteen_bit_timer_i (.pclk, .presetn, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .count_clk,
        .gate_input, .sleep, .overflow_irq, .gate_irq, .wake);
    count_gate_src count_gate_src_i (.count_clk, .gate_input);

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // apb master: request held until pready seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // model: prescaled increments on counted rising edges
    task automatic edges(input int n, input logic act);
        count_gate_src_i.pulses(n);
        repeat (n) if (act) begin
            m_pre++;
            if (m_pre == m_div) begin
                m_pre = 0;
                m_cnt = (m_cnt + 1) % 65536;
            end
        end
        repeat (12) @(posedge pclk);
    endtask : edges
    task automatic wctl(input logic on, input logic wide, input logic us, input logic [1:0] p);
        apb(1'b1, gtimer_pkg::ADDR_TIMER_CTRL, {26'h0, p, 1'b0, us, wide, on});
        m_div = 1 << p;
    endtask : wctl
    // byte pair write: high first, then low clears the prescaler
    task automatic wcnt(input logic [15:0] v);
        apb(1'b1, gtimer_pkg::ADDR_COUNT_HIGH, {24'h0, v[15:8]});
        apb(1'b1, gtimer_pkg::ADDR_COUNT_LOW, {24'h0, v[7:0]});
        m_cnt = v;
        m_pre = 0;
    endtask : wcnt
    task automatic rdcnt();
        apb(1'b0, gtimer_pkg::ADDR_COUNT_LOW, 32'h0);
        lo = rd[7:0];
        apb(1'b0, gtimer_pkg::ADDR_COUNT_HIGH, 32'h0);
        check({16'h0, rd[7:0], lo}, 32'(m_cnt));
    endtask : rdcnt
    // gate level change, then time for the synchroniser and edge logic
    task automatic gate(input logic v);
        count_gate_src_i.set_gate(gsel, v);
        repeat (4) @(posedge pclk);
    endtask : gate
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // ==========================================================
    // watchdog, far beyond the expected thousand or so cycles
    initial begin
        #2_000_000;
        num_errors++;
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        gsel = {$random(seed)} % 32;
        repeat (10) @(posedge pclk);
        check({28'h0, pready, wake, gate_irq, overflow_irq}, 32'h8); // outputs in reset
        presetn <= 1'b1;
        apb(1'b0, 12'h0fc, 32'h0);
        check({31'h0, err}, 32'h1); // unmapped access flags an error
        edges(3, 1'b0);
        rdcnt();
        wctl(1'b1, 1'b0, 1'b0, 2'd0);
        edges(5, 1'b1);
        rdcnt();
        // clock enable low freezes the counter while edges arrive
        clk_en <= 1'b0;
        edges(2, 1'b0);
        clk_en <= 1'b1;
        rdcnt(); // frozen count
        $display("test on_off done");
        // prescale by 2: high write keeps the half step, low write drops it
        wctl(1'b1, 1'b0, 1'b0, 2'd1);
        wcnt(16'h1234);
        edges(1, 1'b1);
        apb(1'b1, gtimer_pkg::ADDR_COUNT_HIGH, 32'h0000_0056);
        m_cnt = (m_cnt % 256) + 16'h5600;
        edges(1, 1'b1);
        rdcnt();
        wcnt(16'h0010);
        edges(1, 1'b1);
        rdcnt();
        $display("test prescale done");
        // wide mode: low read freezes the high byte in the buffer
        wctl(1'b1, 1'b1, 1'b0, 2'd0);
        wcnt(16'h12ff);
        apb(1'b0, gtimer_pkg::ADDR_COUNT_LOW, 32'h0);
        check(rd, 32'h0000_00ff);
        edges(2, 1'b1);
        apb(1'b0, gtimer_pkg::ADDR_COUNT_HIGH, 32'h0);
        check(rd, 32'h0000_0012);
        rdcnt();
        $display("test wide done");
        // unsync counting in sleep, rollover, wake and irq gating
        wctl(1'b1, 1'b0, 1'b1, 2'd0);
        wcnt(16'hfffe);
        apb(1'b1, gtimer_pkg::ADDR_FLAGS, 32'h0);
        apb(1'b1, gtimer_pkg::ADDR_ENABLES, 32'h0000_0001);
        sleep <= 1'b1;
        edges(2, 1'b1);
        check({30'h0, wake, overflow_irq}, 32'h2);
        apb(1'b1, gtimer_pkg::ADDR_ENABLES, 32'h0000_0005);
        repeat (2) @(posedge pclk);
        check({31'h0, overflow_irq}, 32'h1);
        sleep <= 1'b0;
        rdcnt();
        apb(1'b0, gtimer_pkg::ADDR_FLAGS, 32'h0);
        check(rd & 32'h1, 32'h1);
        apb(1'b1, gtimer_pkg::ADDR_FLAGS, 32'h0);
        wctl(1'b1, 1'b0, 1'b0, 2'd0);
        sleep <= 1'b1;
        edges(3, 1'b0);
        sleep <= 1'b0;
        rdcnt();
        $display("test sleep done");
        // gate enable over every polarity and level, random source
        apb(1'b1, gtimer_pkg::ADDR_GATE_SRC, 32'(gsel));
        for (int p = 0; p < 2; p++) begin
            for (int g = 0; g < 2; g++) begin
                count_gate_src_i.set_gate(gsel, g[0]);
                apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, {24'h0, 1'b1, p[0], 6'h00});
                edges(4, p == g);
                rdcnt();
            end
        end
        $display("test gate done");
        // level status and gate event with gate control off
        apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, 32'h0000_0040);
        count_gate_src_i.set_gate(gsel, 1'b1);
        apb(1'b1, gtimer_pkg::ADDR_ENABLES, 32'h0000_0006);
        apb(1'b1, gtimer_pkg::ADDR_FLAGS, 32'h0);
        apb(1'b0, gtimer_pkg::ADDR_GATE_CTRL, 32'h0);
        check(rd & 32'h4, 32'h4);
        count_gate_src_i.set_gate(gsel, 1'b0);
        repeat (8) @(posedge pclk);
        check({31'h0, gate_irq}, 32'h1);
        apb(1'b0, gtimer_pkg::ADDR_FLAGS, 32'h0);
        check(rd & 32'h2, 32'h2);
        $display("test gate_event done");
        // one-shot: mode first, then arm; only the first gate pulse is counted
        apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, 32'h0000_00d0);
        apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, 32'h0000_00d8);
        edges(2, 1'b0);
        gate(1'b1);
        edges(3, 1'b1);
        gate(1'b0);
        gate(1'b1);
        edges(2, 1'b0);
        rdcnt();
        apb(1'b0, gtimer_pkg::ADDR_GATE_CTRL, 32'h0);
        check(rd & 32'h8, 32'h0);
        apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, 32'h0000_00d8);
        apb(1'b0, gtimer_pkg::ADDR_GATE_CTRL, 32'h0);
        check(rd & 32'h8, 32'h8);
        apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, 32'h0000_00c0);
        apb(1'b0, gtimer_pkg::ADDR_GATE_CTRL, 32'h0);
        check(rd & 32'h8, 32'h0);
        $display("test one_shot done");
        // toggle plus one-shot: counting spans one whole gate period
        apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, 32'h0000_00f0); // polarity kept
        apb(1'b1, gtimer_pkg::ADDR_GATE_CTRL, 32'h0000_00f8);
        gate(1'b0);
        gate(1'b1);
        edges(2, 1'b1);
        gate(1'b0);
        edges(2, 1'b1);
        gate(1'b1);
        edges(2, 1'b0);
        rdcnt();
        apb(1'b0, gtimer_pkg::ADDR_GATE_CTRL, 32'h0);
        check(rd & 32'h8, 32'h0);
        $display("test toggle done");
        conclude();
    end
endmodule : gated_sixteen_bit_timer_tb_top

// ===== hw/gated_sixteen_bit_timer.sv
// Function
// - unsync bit: count on sampled clock edges, bypass the phase-clock resample
// - unsync external clock keeps counting in sleep; overflow wakes the core
// - sync/unsync switch may drop or add one increment
// - byte reads always return a stable registered value
// - wide mode: high address goes only through the high buffer
// - wide mode: low read copies high count into the buffer
// - wide mode: low write loads buffer and low byte together
// - high write keeps prescaler; low write clears it
// - gate enable: count only while gate active per polarity
// - five-bit source select; polarity applies to chosen source
// - toggle mode flips on gate rising edge; cleared when off
// - one-shot: armed bit then count from next gate rising edge
// - trailing gate edge clears armed and blocks further counting
// - clearing one-shot mode clears armed
// - toggle plus one-shot together measure one full gate period
// - gate level status readable even with gate disabled
// - falling gate level sets gate event flag; interrupt if enabled
// - rollover sets overflow flag; interrupt needs on, enable, global
// - sleep counting only in unsync mode; overflow wakes the device
// - counting needs on bit; gate control then decides
`timescale 1ns/1ns
module gated_sixteen_bit_timer #(
    parameter int GATE_SOURCES = gtimer_pkg::GATE_SOURCES // selectable gate inputs
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic count_clk, // external count clock pin
    input wire logic [GATE_SOURCES-1:0] gate_input, // candidate gate sources
    input wire logic sleep, // core is asleep
    output logic overflow_irq, // overflow interrupt
    output logic gate_irq, // gate event interrupt
    output logic wake // wake request from sleep
);
    // ==========================================================
    // elaboration check: a five-bit select reaches exactly this many sources
    if (GATE_SOURCES != 32) begin : g_bad_sources
        $error("gate source count must be 32");
    end

    // ==========================================================
    // apb decode
    logic acc, wr, rd, mapped;
    assign acc = psel && penable && clk_en;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign mapped = (paddr == gtimer_pkg::ADDR_COUNT_LOW) ||
        (paddr == gtimer_pkg::ADDR_COUNT_HIGH) || (paddr == gtimer_pkg::ADDR_TIMER_CTRL) ||
        (paddr == gtimer_pkg::ADDR_GATE_CTRL) || (paddr == gtimer_pkg::ADDR_GATE_SRC) ||
        (paddr == gtimer_pkg::ADDR_FLAGS) || (paddr == gtimer_pkg::ADDR_ENABLES);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    logic wr_lo, wr_hi, rd_lo;
    assign wr_lo = wr && paddr == gtimer_pkg::ADDR_COUNT_LOW;
    assign wr_hi = wr && paddr == gtimer_pkg::ADDR_COUNT_HIGH;
    assign rd_lo = rd && paddr == gtimer_pkg::ADDR_COUNT_LOW;

    // ==========================================================
    // control registers
    gtimer_pkg::timer_ctrl_t tc_q;
    gtimer_pkg::gate_ctrl_t gc_q;
    logic [4:0] gss_q;
    logic ovf_ie_q, gate_ie_q, gie_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_q <= '0;
            gc_q <= '0;
            gss_q <= 5'h00;
            ovf_ie_q <= 1'b0;
            gate_ie_q <= 1'b0;
            gie_q <= 1'b0;
        end else if (wr) begin
            if (paddr == gtimer_pkg::ADDR_TIMER_CTRL) begin
                tc_q.on <= pwdata[gtimer_pkg::TC_ON];
                tc_q.wide <= pwdata[gtimer_pkg::TC_WIDE];
                tc_q.unsync <= pwdata[gtimer_pkg::TC_UNSYNC];
                tc_q.prescale <= pwdata[gtimer_pkg::TC_PRE_LO +: 2];
            end
            if (paddr == gtimer_pkg::ADDR_GATE_CTRL) begin
                gc_q.enable <= pwdata[gtimer_pkg::GC_EN];
                gc_q.polarity <= pwdata[gtimer_pkg::GC_POL];
                gc_q.toggle <= pwdata[gtimer_pkg::GC_TOGGLE];
                gc_q.oneshot <= pwdata[gtimer_pkg::GC_ONESHOT];
            end
            // gate source select, five bits
            if (paddr == gtimer_pkg::ADDR_GATE_SRC) gss_q <= pwdata[4:0];
            if (paddr == gtimer_pkg::ADDR_ENABLES) begin
                ovf_ie_q <= pwdata[gtimer_pkg::FL_OVF];
                gate_ie_q <= pwdata[gtimer_pkg::FL_GATE];
                gie_q <= pwdata[gtimer_pkg::EN_GLOBAL];
            end
        end
    end

    // ==========================================================
    // pin synchronisers: first stage feeds only the second
    logic [1:0] clk_sync_q;
    logic [GATE_SOURCES-1:0] gate_s1_q, gate_s2_q;
    logic clk_prev_q, clk_res_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync_q <= 2'b00;
            gate_s1_q <= '0;
            gate_s2_q <= '0;
        end else if (clk_en) begin
            clk_sync_q <= {clk_sync_q[0], count_clk};
            gate_s1_q <= gate_input;
            gate_s2_q <= gate_s1_q;
        end
    end
    // sync mode adds one extra resample stage, the phase-clock alignment;
    // unsync bypasses it, so a mode switch can drop or add one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_res_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else if (clk_en) begin
            clk_res_q <= clk_sync_q[1];
            clk_prev_q <= tc_q.unsync ? clk_sync_q[1] : clk_res_q;
        end
    end
    logic clk_now, clk_rise;
    assign clk_now = tc_q.unsync ? clk_sync_q[1] : clk_res_q;
    assign clk_rise = clk_now && !clk_prev_q;

    // ==========================================================
    // gate path: select, polarity, toggle, one-shot
    logic gate_pol, gate_pol_prev_q, gate_rise;
    assign gate_pol = gate_s2_q[gss_q] ~^ gc_q.polarity;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gate_pol_prev_q <= 1'b0;
        else if (clk_en) gate_pol_prev_q <= gate_pol;
    end
    assign gate_rise = gate_pol && !gate_pol_prev_q;

    logic tog_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tog_q <= 1'b0;
        else if (clk_en) begin
            if (!gc_q.toggle) tog_q <= 1'b0; // held clear
            else if (gate_rise) tog_q <= !tog_q;
        end
    end
    logic gate_tg;
    assign gate_tg = gc_q.toggle ? tog_q : gate_pol;

    // one-shot: armed waits for rising edge, then window runs to trailing edge
    logic armed_q, window_q, gate_tg_prev_q;
    logic tg_rise, tg_fall;
    assign tg_rise = gate_tg && !gate_tg_prev_q;
    assign tg_fall = !gate_tg && gate_tg_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gate_tg_prev_q <= 1'b0;
        else if (clk_en) gate_tg_prev_q <= gate_tg;
    end
    logic wr_gc;
    assign wr_gc = wr && paddr == gtimer_pkg::ADDR_GATE_CTRL;
    // trailing edge beats an arm write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
            window_q <= 1'b0;
        end else if (clk_en) begin
            if (!gc_q.oneshot) begin
                armed_q <= 1'b0;
                window_q <= 1'b0;
            end else if (window_q && tg_fall) begin
                armed_q <= 1'b0; // self clear at trailing edge
                window_q <= 1'b0;
            end else if (armed_q && tg_rise) begin
                window_q <= 1'b1;
            end else if (wr_gc && pwdata[gtimer_pkg::GC_ARMED]) begin
                armed_q <= 1'b1;
            end
            if (wr_gc && !pwdata[gtimer_pkg::GC_ONESHOT]) armed_q <= 1'b0;
        end
    end
    logic gate_open;
    assign gate_open = gc_q.oneshot ? (window_q && gate_tg) : gate_tg;

    // gate level status and its falling edge
    logic level_prev_q, gate_flag_q, gate_fall;
    assign gate_fall = level_prev_q && !gate_open;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) level_prev_q <= 1'b0;
        else if (clk_en) level_prev_q <= gate_open;
    end

    // ==========================================================
    // prescaler and counter; unsync counting runs on in sleep
    logic [2:0] pre_q;
    logic [15:0] count_q;
    logic [7:0] hbuf_q;
    logic run, tick, ovf_evt;
    // sleep freezes synchronous counting; only unsync mode runs on
    assign run = tc_q.on && (!gc_q.enable || gate_open) &&
        (!sleep || tc_q.unsync);
    logic [2:0] pre_mask;
    assign pre_mask = (3'h1 << tc_q.prescale) - 3'h1;
    assign tick = run && clk_rise && ((pre_q & pre_mask) == pre_mask);
    assign ovf_evt = tick && count_q == gtimer_pkg::COUNT_MAX;
    // prescaler is hidden from software; only a low write clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pre_q <= 3'h0;
        else if (clk_en) begin
            if (wr_lo) pre_q <= 3'h0;
            else if (run && clk_rise) pre_q <= pre_q + 3'h1;
        end
    end
    // writes win over a coinciding increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) count_q <= gtimer_pkg::COUNT_RESET;
        else if (clk_en) begin
            if (wr_lo && tc_q.wide) count_q <= {hbuf_q, pwdata[7:0]};
            else if (wr_lo) count_q[7:0] <= pwdata[7:0];
            else if (wr_hi && !tc_q.wide) count_q[15:8] <= pwdata[7:0];
            else if (tick) count_q <= count_q + 16'h0001;
        end
    end
    // high buffer only moves in wide mode, so byte mode reads stay direct
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hbuf_q <= gtimer_pkg::BYTE_RESET;
        else if (clk_en && tc_q.wide) begin
            if (wr_hi) hbuf_q <= pwdata[7:0];
            else if (rd_lo) hbuf_q <= count_q[15:8];
        end
    end

    // ==========================================================
    // sticky flags, set wins over software clear
    logic ovf_flag_q;
    logic wr_fl;
    assign wr_fl = wr && paddr == gtimer_pkg::ADDR_FLAGS;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_q <= 1'b0;
            gate_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (ovf_evt) ovf_flag_q <= 1'b1;
            else if (wr_fl) ovf_flag_q <= pwdata[gtimer_pkg::FL_OVF];
            if (gate_fall) gate_flag_q <= 1'b1;
            else if (wr_fl) gate_flag_q <= pwdata[gtimer_pkg::FL_GATE];
        end
    end
    // wake does not need global enable; the irq lines do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq <= 1'b0;
            gate_irq <= 1'b0;
            wake <= 1'b0;
        end else if (clk_en) begin
            overflow_irq <= ovf_flag_q && ovf_ie_q && tc_q.on && gie_q;
            gate_irq <= gate_flag_q && gate_ie_q && gie_q;
            wake <= sleep && ovf_flag_q && ovf_ie_q && tc_q.on;
        end
    end

    // ==========================================================
    // read mux; data comes from flops; only wide mode keeps a low/high byte pair from tearing
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            gtimer_pkg::ADDR_COUNT_LOW: rdata_d[7:0] = count_q[7:0];
            gtimer_pkg::ADDR_COUNT_HIGH: rdata_d[7:0] = tc_q.wide ? hbuf_q : count_q[15:8];
            gtimer_pkg::ADDR_TIMER_CTRL: rdata_d[7:0] = {2'b00, tc_q.prescale, 1'b0,
                tc_q.unsync, tc_q.wide, tc_q.on};
            gtimer_pkg::ADDR_GATE_CTRL: rdata_d[7:0] = {gc_q.enable, gc_q.polarity,
                gc_q.toggle, gc_q.oneshot, armed_q, level_prev_q, 2'b00};
            gtimer_pkg::ADDR_GATE_SRC: rdata_d[4:0] = gss_q;
            gtimer_pkg::ADDR_FLAGS: rdata_d[1:0] = {gate_flag_q, ovf_flag_q};
            gtimer_pkg::ADDR_ENABLES: rdata_d[2:0] = {gie_q, gate_ie_q, ovf_ie_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end
    assign prdata = rdata_d;

    // ==========================================================
    // assertions
    property p_ovf_sets;
        @(posedge pclk) disable iff (!presetn) (ovf_evt && clk_en) |=> ovf_flag_q;
    endproperty
    a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag missed");
    property p_roll;
        @(posedge pclk) disable iff (!presetn)
            (ovf_evt && clk_en && !wr_lo && !wr_hi) |=> count_q == 16'h0000;
    endproperty
    a_roll: assert property (p_roll) else $error("no rollover to zero");
    property p_off_hold;
        @(posedge pclk) disable iff (!presetn)
            (!tc_q.on && !wr_lo && !wr_hi) |=> $stable(count_q);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("counted while off");
    property p_low_rd_copy;
        @(posedge pclk) disable iff (!presetn)
            (rd_lo && tc_q.wide) |=> hbuf_q == $past(count_q[15:8]);
    endproperty
    a_low_rd_copy: assert property (p_low_rd_copy) else $error("buffer not loaded");
    property p_wide_wr;
        @(posedge pclk) disable iff (!presetn)
            (wr_lo && tc_q.wide) |=> count_q == {$past(hbuf_q), $past(pwdata[7:0])};
    endproperty
    a_wide_wr: assert property (p_wide_wr) else $error("wide write wrong");
    property p_pre_clr;
        @(posedge pclk) disable iff (!presetn) wr_lo |=> pre_q == 3'h0;
    endproperty
    a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared");
    property p_tog_clear;
        @(posedge pclk) disable iff (!presetn) (!gc_q.toggle && clk_en) |=> !tog_q;
    endproperty
    a_tog_clear: assert property (p_tog_clear) else $error("toggle flop not clear");
    property p_oneshot_clr;
        @(posedge pclk) disable iff (!presetn) (!gc_q.oneshot && !wr_gc) |-> ##1 !armed_q [*2];
    endproperty
    a_oneshot_clr: assert property (p_oneshot_clr) else $error("armed stays set");
    property p_gate_flag;
        @(posedge pclk) disable iff (!presetn) (gate_fall && clk_en) |=> gate_flag_q;
    endproperty
    a_gate_flag: assert property (p_gate_flag) else $error("gate flag missed");
    property p_gated_hold;
        @(posedge pclk) disable iff (!presetn)
            (gc_q.enable && !gate_open && !wr_lo && !wr_hi) |=> $stable(count_q);
    endproperty
    a_gated_hold: assert property (p_gated_hold) else $error("counted gate shut");
    property p_hi_keep;
        @(posedge pclk) disable iff (!presetn)
            (wr_hi && tc_q.wide && !tick) |=> $stable(count_q);
    endproperty
    a_hi_keep: assert property (p_hi_keep) else $error("high write hit count");
    property p_hi_pre;
        @(posedge pclk) disable iff (!presetn)
            (wr_hi && !clk_rise) |=> $stable(pre_q);
    endproperty
    a_hi_pre: assert property (p_hi_pre) else $error("prescaler moved");
    property p_trail_done;
        @(posedge pclk) disable iff (!presetn)
            (clk_en && gc_q.oneshot && window_q && tg_fall) |=> !armed_q && !window_q;
    endproperty
    a_trail_done: assert property (p_trail_done) else $error("armed kept");
    property p_sleep_hold;
        @(posedge pclk) disable iff (!presetn)
            (sleep && !tc_q.unsync && !wr_lo && !wr_hi) |=> $stable(count_q);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sync count in sleep");
    property p_irq_global;
        @(posedge pclk) disable iff (!presetn)
            overflow_irq |-> $past(gie_q) && $past(ovf_ie_q);
    endproperty
    a_irq_global: assert property (p_irq_global) else $error("irq without enables");
    property p_wake_sleep;
        @(posedge pclk) disable iff (!presetn)
            (wake && $past(clk_en)) |-> $past(sleep);
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");

    // ==========================================================
    // cover points
    c_ovf: cover property (@(posedge pclk) ovf_evt);
    c_window: cover property (@(posedge pclk) window_q ##[1:50] !armed_q);
    c_wake: cover property (@(posedge pclk) wake);
    c_gate_irq: cover property (@(posedge pclk) gate_irq);
    c_period: cover property (@(posedge pclk) gc_q.toggle && window_q && tg_fall);
endmodule : gated_sixteen_bit_timer
